//--- dv/ptu_mem_model.sv
`timescale 1ns/10ps
module ptu_mem_model (
  // Clock and reset
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  // Request
  input wire logic        req_i,
  input wire logic        we_i,
  input wire logic [19:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [3:0]  wait_i,
  // Answer
  output logic [15:0]     rdata_o,
  output logic            ack_o
);
  logic [15:0] mem [logic [19:0]];
  logic [3:0]  cnt;
  // Read data toggles outside an answer so a stale word never passes as fresh.
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
      cnt <= 4'h0;
      rdata_o <= 16'h5a5a;
    end else if (!ack_o && req_i && cnt >= wait_i) begin
      ack_o <= 1'b1;
      cnt <= 4'h0;
      rdata_o <= mem.exists(addr_i) ? mem[addr_i] : 16'h0;
      if (we_i) mem[addr_i] = wdata_i;
    end else begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      cnt <= (req_i && !ack_o) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule

//--- dv/ptu_tb_top.sv
`timescale 1ns/10ps
module ptu_tb_top;
  logic        sys_clk_i = 1'b0, rst_n_i = 1'b0, start_i = 1'b0, ind_reg_i = 1'b0;
  logic        carry_flag_i = 1'b0, zero_flag_i = 1'b0, sign_flag_i = 1'b0;
  logic        overflow_flag_i = 1'b0, parity_flag_i = 1'b0;
  logic [3:0]  op_i = 4'h0, cc_i = 4'h0, wait_cnt = 4'h0;
  logic [15:0] next_ip_i = 16'h0, disp_i = 16'h0, target_off_i = 16'h0, target_seg_i = 16'h0;
  logic [15:0] ind_addr_i = 16'h0, data_seg_i = 16'h0, pop_val_i = 16'h0, stack_seg_i = 16'h0;
  logic        busy_o, done_o, queue_flush_o, direct_fetch_o, mem_req_o, mem_we_o, mem_ack_i;
  logic [15:0] instr_pointer_o, code_segment_base_o, stack_ptr_o, mem_wdata_o, mem_rdata_i;
  logic [19:0] fetch_addr_o, mem_addr_o;
  int unsigned n_mismatch = 0, samples_checked = 0, cycles = 0;
  logic [31:0] seed = 32'h177eb;
  logic [15:0] ip, cs, sp, ss;
  logic [15:0] m [logic [19:0]];
  logic [19:0] pq [$];

  ptu_top i_dut (.*);
  ptu_mem_model u_mem (
    .sys_clk_i (sys_clk_i), .rst_n_i (rst_n_i), .req_i (mem_req_o), .we_i (mem_we_o),
    .addr_i (mem_addr_o), .wdata_i (mem_wdata_o), .wait_i (wait_cnt),
    .rdata_o (mem_rdata_i), .ack_o (mem_ack_i));

  initial forever #50 sys_clk_i = ~sys_clk_i;

  task automatic end_of_test();
    if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  function automatic logic [15:0] rnd();
    repeat (16) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction

  function automatic logic [19:0] sa(input logic [15:0] s, input logic [15:0] o);
    return {s, 4'h0} + {4'h0, o};
  endfunction

  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // The bench store and the partner store are preloaded together.
  task automatic pl(input logic [19:0] a, input logic [15:0] v);
    m[a] = v;
    u_mem.mem[a] = v;
  endtask

  task automatic push(input logic [15:0] v);
    sp = sp - 16'h2;
    m[sa(ss, sp)] = v;
    pq.push_back(sa(ss, sp));
  endtask

  task automatic pop(output logic [15:0] v);
    if (!m.exists(sa(ss, sp))) pl(sa(ss, sp), rnd());
    v = m[sa(ss, sp)];
    sp = sp + 16'h2;
  endtask

  function automatic logic cond(input logic [3:0] c, input logic [4:0] f);
    logic r;
    case (c[3:1])
      3'h0: r = f[1];
      3'h1: r = f[4];
      3'h2: r = f[3];
      3'h3: r = f[4] | f[3];
      3'h4: r = f[2];
      3'h5: r = f[0];
      3'h6: r = f[2] ^ f[1];
      default: r = (f[2] ^ f[1]) | f[3];
    endcase
    return r ^ c[0];
  endfunction

  task automatic do_reset();
    rst_n_i <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    ip = ptu_pkg::IP_RESET;
    cs = ptu_pkg::CS_RESET;
    sp = ptu_pkg::SP_RESET;
    ss = rnd();
    #1;
    chk(instr_pointer_o, ip);
    chk(code_segment_base_o, cs);
    chk(stack_ptr_o, sp);
    chk(fetch_addr_o, sa(cs, ip));
    chk({busy_o, done_o, queue_flush_o, mem_req_o}, 4'h0);
  endtask

  task automatic run(input logic [3:0] op, input logic [3:0] cc);
    logic [15:0] nip, d, off, seg, ia, ds, pv, w0, w1;
    logic [4:0]  f, fl;
    logic        ir, hold, tk;
    int          n;
    nip = (op >= 4'hb) ? ip : rnd();
    d = rnd();
    off = rnd();
    seg = rnd();
    pv = rnd();
    ds = rnd();
    ia = rnd() & 16'h7ffe;
    {ir, hold, f} = seed[22:16];
    hold = hold && op < 4'hb;
    pl(sa(ds, ia), rnd());
    pl(sa(ds, ia) + 20'h2, rnd());
    w0 = m[sa(ds, ia)];
    w1 = m[sa(ds, ia) + 20'h2];
    tk = 1'b1;
    pq.delete();
    case (op)
      4'h0: begin push(nip); ip = nip + d; end
      4'h1: begin push(nip); ip = ir ? off : w0; end
      4'h2: begin push(cs); push(nip); cs = seg; ip = off; end
      4'h3: begin push(cs); push(nip); cs = w1; ip = w0; end
      4'h4: begin pop(ip); sp = sp + pv; end
      4'h5: begin pop(ip); pop(cs); sp = sp + pv; end
      4'h6: ip = nip + {{8{d[7]}}, d[7:0]};
      4'h7: ip = nip + d;
      4'h8: ip = ir ? off : w0;
      4'h9: begin ip = off; cs = seg; end
      4'ha: begin ip = w0; cs = w1; end
      4'hb: begin tk = cond(cc, f); if (tk) ip = ip + {{8{d[7]}}, d[7:0]}; end
      default: tk = 1'b0;
    endcase
    @(posedge sys_clk_i);
    {op_i, cc_i, next_ip_i, disp_i, target_off_i, target_seg_i} <= {op, cc, nip, d, off, seg};
    {ind_reg_i, ind_addr_i, data_seg_i, pop_val_i, stack_seg_i} <= {ir, ia, ds, pv, ss};
    {carry_flag_i, zero_flag_i, sign_flag_i, overflow_flag_i, parity_flag_i} <= f;
    wait_cnt <= {1'b0, seed[25:23]};
    start_i <= 1'b1;
    n = 0;
    fl = 5'h0;
    do begin
      @(posedge sys_clk_i);
      start_i <= (n == 0) && hold;
      #1;
      fl = fl + queue_flush_o;
      n++;
    end while (done_o !== 1'b1 && n < 300);
    chk(done_o, 1'b1);
    chk(instr_pointer_o, ip);
    chk(code_segment_base_o, cs);
    chk(stack_ptr_o, sp);
    chk(fetch_addr_o, sa(cs, ip));
    chk(fl, tk);
    foreach (pq[i]) chk(u_mem.mem[pq[i]], m[pq[i]]);
  endtask

  initial begin
    do_reset();
    for (int i = 0; i < 16; i++) run(4'(i), 4'h0);
    for (int i = 0; i < 48; i++) run(4'hb, 4'(i));
    do_reset();
    for (int i = 0; i < 150; i++) run(4'(rnd() % 16'h000c), seed[7:4]);
    end_of_test();
  end
endmodule

//--- dv/ptu_top_monitor.sv
`timescale 1ns/10ps
module ptu_top_monitor (
  // Clock, reset and issue
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic        start_i,
  input wire logic [3:0]  op_i,
  input wire logic [3:0]  cc_i,
  input wire logic [15:0] next_ip_i,
  input wire logic [15:0] disp_i,
  input wire logic        zero_flag_i,
  input wire logic [15:0] stack_seg_i,
  // Design outputs
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic [15:0] instr_pointer_o,
  input wire logic [15:0] stack_ptr_o,
  input wire logic [15:0] code_segment_base_o,
  input wire logic [19:0] fetch_addr_o,
  input wire logic        queue_flush_o,
  input wire logic        direct_fetch_o,
  input wire logic        mem_req_o,
  input wire logic        mem_we_o,
  input wire logic [19:0] mem_addr_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic        take;
  logic        beq;
  logic        jnear;
  logic [15:0] sdisp;
  assign take = start_i && !busy_o;
  assign beq = take && op_i == ptu_pkg::PTU_OP_JCC && cc_i == ptu_pkg::CC_E;
  assign jnear = take && op_i == ptu_pkg::PTU_OP_JMP_NEAR;
  assign sdisp = {{8{disp_i[7]}}, disp_i[7:0]};
  AST_FETCH:
    assert property (fetch_addr_o == {code_segment_base_o, 4'h0} + {4'h0, instr_pointer_o})
      else $error("fetch address wrong");
  AST_FLUSH_DIRECT:
    assert property (queue_flush_o |-> direct_fetch_o) else $error("flush without fetch");
  AST_FLUSH_DONE:
    assert property (queue_flush_o |=> done_o) else $error("no done after flush");
  // The pointer also advances to the next instruction when a transfer is issued.
  AST_IP_FLUSH:
    assert property (!$stable(instr_pointer_o) |-> queue_flush_o || $past(take))
      else $error("ip moved unflushed");
  AST_IP_ADVANCE:
    assert property (take |=> instr_pointer_o == $past(next_ip_i))
      else $error("pointer not advanced at issue");
  AST_JMP_NOSTACK:
    assert property (jnear |=> (!mem_req_o && $stable(stack_ptr_o)) [*2] ##1 done_o)
      else $error("near jump touched stack");
  AST_JMP_TARGET:
    assert property (jnear |-> ##2 instr_pointer_o == $past(next_ip_i, 2) + $past(disp_i, 2))
      else $error("near jump target wrong");
  AST_JCC_SKIP:
    assert property (beq && !zero_flag_i |=> done_o && !queue_flush_o)
      else $error("untaken branch wrong");
  AST_JCC_TAKE:
    assert property (beq && zero_flag_i |->
      ##2 instr_pointer_o == $past(next_ip_i, 2) + $past(sdisp, 2))
      else $error("taken branch target wrong");
  AST_PUSH_ADDR:
    assert property ($rose(mem_req_o) && mem_we_o |->
      mem_addr_o == {stack_seg_i, 4'h0} + {4'h0, stack_ptr_o}) else $error("push address wrong");
endmodule

bind ptu_top ptu_top_monitor u_mon (.*);

//--- hdl/ptu_cond_eval.sv
`timescale 1ns/10ps
module ptu_cond_eval (
  // Condition select and flags
  input  wire logic [3:0] cc_i,
  input  wire logic       carry_flag_i,
  input  wire logic       zero_flag_i,
  input  wire logic       sign_flag_i,
  input  wire logic       overflow_flag_i,
  input  wire logic       parity_flag_i,
  // Result
  output logic            taken_o
);
  logic raw;
  logic sxo;
  always_comb begin
    sxo = sign_flag_i ^ overflow_flag_i;
    unique case ({cc_i[3:1], 1'b0})
      ptu_pkg::CC_O:  raw = overflow_flag_i;
      ptu_pkg::CC_B:  raw = carry_flag_i;
      ptu_pkg::CC_E:  raw = zero_flag_i;
      ptu_pkg::CC_BE: raw = carry_flag_i | zero_flag_i;
      ptu_pkg::CC_S:  raw = sign_flag_i;
      ptu_pkg::CC_P:  raw = parity_flag_i;
      ptu_pkg::CC_L:  raw = sxo;
      default:        raw = sxo | zero_flag_i;
    endcase
    taken_o = raw ^ cc_i[0];
  end
endmodule

//--- hdl/ptu_mem_if.sv
`timescale 1ns/10ps
interface ptu_mem_if;
  logic        req;
  logic        we;
  logic [19:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        ack;
  modport master (output req, output we, output addr, output wdata, input rdata, input ack);
  modport slave  (input req, input we, input addr, input wdata, output rdata, output ack);
endinterface

//--- hdl/ptu_mem_port.sv
`timescale 1ns/10ps
module ptu_mem_port (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // Request from sequencer
  input  wire logic        go_i,
  input  wire logic        we_i,
  input  wire logic [19:0] addr_i,
  input  wire logic [15:0] wdata_i,
  output logic             done_o,
  output logic [15:0]      rdata_o,
  // Memory side
  ptu_mem_if.master        mem
);
  logic        busy_ff,  nxt_busy;
  logic        we_ff,    nxt_we;
  logic [19:0] addr_ff,  nxt_addr;
  logic [15:0] wdata_ff, nxt_wdata;
  logic [15:0] rdata_ff, nxt_rdata;
  logic        done_ff,  nxt_done;

  always_comb begin
    nxt_busy  = busy_ff;
    nxt_we    = we_ff;
    nxt_addr  = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_rdata = rdata_ff;
    nxt_done  = 1'b0;
    if (busy_ff) begin
      if (mem.ack) begin
        nxt_busy  = 1'b0;
        nxt_done  = 1'b1;
        nxt_rdata = mem.rdata;
      end
    end else if (go_i) begin
      nxt_busy  = 1'b1;
      nxt_we    = we_i;
      nxt_addr  = addr_i;
      nxt_wdata = wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_ff  <= 1'b0;
      we_ff    <= 1'b0;
      addr_ff  <= 20'h00000;
      wdata_ff <= 16'h0000;
      rdata_ff <= 16'h0000;
      done_ff  <= 1'b0;
    end else begin
      busy_ff  <= nxt_busy;
      we_ff    <= nxt_we;
      addr_ff  <= nxt_addr;
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
      done_ff  <= nxt_done;
    end
  end

  assign mem.req   = busy_ff;
  assign mem.we    = we_ff;
  assign mem.addr  = addr_ff;
  assign mem.wdata = wdata_ff;
  assign done_o    = done_ff;
  assign rdata_o   = rdata_ff;
endmodule

//--- hdl/ptu_pkg.sv
// Function
// - Fetch address is code base plus pointer.
// - Transfer flushes queue, direct fetch, then refill.
// - Control transfers never change processor flags.
// - Saved pointer addresses instruction after call.
// - Near direct call pushes, adds displacement.
// - Near indirect call pushes, loads operand word.
// - Far direct call pushes both, loads both.
// - Far indirect call loads segment second, offset first.
// - Return pops offset, far also pops segment.
// - Return pop value added after popping.
// - Jumps never touch stack or stack pointer.
// - Near jump short or word displacement.
// - Near indirect jump loads operand word.
// - Far direct jump loads offset and segment.
// - Far indirect jump: first offset, second segment.
// - Conditional jump taken only when condition true.
// - Conditional displacement relative to next instruction.
// - Unsigned conditions from carry and zero.
// - Signed conditions from sign xor overflow.
// - Overflow, sign, parity tests and negations.
package ptu_pkg;
  localparam int unsigned WORD_W   = 16;
  localparam int unsigned ADDR_W   = 20;
  localparam int unsigned SEG_SHIFT = 4;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] IP_RESET  = 16'h0000;
  localparam logic [15:0] CS_RESET  = 16'hffff;
  localparam logic [15:0] SP_RESET  = 16'h0000;

  typedef enum logic [3:0] {
    PTU_OP_CALL_NEAR_DIR = 4'h0,
    PTU_OP_CALL_NEAR_IND = 4'h1,
    PTU_OP_CALL_FAR_DIR  = 4'h2,
    PTU_OP_CALL_FAR_IND  = 4'h3,
    PTU_OP_RET_NEAR      = 4'h4,
    PTU_OP_RET_FAR       = 4'h5,
    PTU_OP_JMP_SHORT     = 4'h6,
    PTU_OP_JMP_NEAR      = 4'h7,
    PTU_OP_JMP_NEAR_IND  = 4'h8,
    PTU_OP_JMP_FAR_DIR   = 4'h9,
    PTU_OP_JMP_FAR_IND   = 4'ha,
    PTU_OP_JCC           = 4'hb
  } ptu_op_e;

  // Condition codes in the conventional 4-bit order; bit 0 negates.
  localparam logic [3:0] CC_O  = 4'h0;
  localparam logic [3:0] CC_B  = 4'h2;
  localparam logic [3:0] CC_E  = 4'h4;
  localparam logic [3:0] CC_BE = 4'h6;
  localparam logic [3:0] CC_S  = 4'h8;
  localparam logic [3:0] CC_P  = 4'ha;
  localparam logic [3:0] CC_L  = 4'hc;
  localparam logic [3:0] CC_LE = 4'he;
endpackage

//--- hdl/ptu_top.sv
`timescale 1ns/10ps
module ptu_top (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // Instruction issue from the execution_unit
  input  wire logic        start_i,
  input  wire logic [3:0]  op_i,
  input  wire logic [3:0]  cc_i,
  input  wire logic [15:0] next_ip_i,
  input  wire logic [15:0] disp_i,
  input  wire logic [15:0] target_off_i,
  input  wire logic [15:0] target_seg_i,
  input  wire logic        ind_reg_i,
  input  wire logic [15:0] ind_addr_i,
  input  wire logic [15:0] data_seg_i,
  input  wire logic [15:0] pop_val_i,
  output logic             busy_o,
  output logic             done_o,
  // Processor flags and stack segment, only read here
  input  wire logic        carry_flag_i,
  input  wire logic        zero_flag_i,
  input  wire logic        sign_flag_i,
  input  wire logic        overflow_flag_i,
  input  wire logic        parity_flag_i,
  input  wire logic [15:0] stack_seg_i,
  // Architectural state
  output logic [15:0]      instr_pointer_o,
  output logic [15:0]      code_segment_base_o,
  output logic [15:0]      stack_ptr_o,
  output logic [19:0]      fetch_addr_o,
  // Prefetch control for the bus_interface_unit
  output logic             queue_flush_o,
  output logic             direct_fetch_o,
  // Memory port
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic [19:0]      mem_addr_o,
  output logic [15:0]      mem_wdata_o,
  input  wire logic [15:0] mem_rdata_i,
  input  wire logic        mem_ack_i
);
  typedef enum logic [7:0] {
    S_IDLE  = 8'h01,
    S_PUSH1 = 8'h02,
    S_PUSH2 = 8'h04,
    S_RD1   = 8'h08,
    S_RD2   = 8'h10,
    S_WAIT  = 8'h20,
    S_XFER  = 8'h40,
    S_FLUSH = 8'h80
  } ptu_state_e;

  ptu_mem_if mem_bus ();

  ptu_state_e  st_ff,    nxt_st;
  ptu_state_e  ret_ff,   nxt_ret;
  logic [3:0]  op_ff,    nxt_op;
  logic [15:0] ip_ff,    nxt_ip;
  logic [15:0] cs_ff,    nxt_cs;
  logic [15:0] sp_ff,    nxt_sp;
  logic [15:0] new_ip_ff, nxt_new_ip;
  logic [15:0] new_cs_ff, nxt_new_cs;
  logic [15:0] ptr_ff,   nxt_ptr;
  logic [15:0] pop_ff,   nxt_pop;
  logic [15:0] pseg_ff,  nxt_pseg;
  logic        done_ff,  nxt_done;
  logic        flush_ff, nxt_flush;
  logic        go;
  logic        we;
  logic [19:0] addr;
  logic [15:0] wdata;
  logic        port_done;
  logic [15:0] port_rdata;
  logic        cond_taken;

  function automatic logic [19:0] phys(input logic [15:0] seg, input logic [15:0] off);
    phys = {seg, 4'h0} + {4'h0, off};
  endfunction

  ptu_cond_eval u_cond (
    .cc_i            (cc_i),
    .carry_flag_i    (carry_flag_i),
    .zero_flag_i     (zero_flag_i),
    .sign_flag_i     (sign_flag_i),
    .overflow_flag_i (overflow_flag_i),
    .parity_flag_i   (parity_flag_i),
    .taken_o         (cond_taken)
  );

  ptu_mem_port u_port (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .go_i      (go),
    .we_i      (we),
    .addr_i    (addr),
    .wdata_i   (wdata),
    .done_o    (port_done),
    .rdata_o   (port_rdata),
    .mem       (mem_bus.master)
  );

  assign mem_req_o     = mem_bus.req;
  assign mem_we_o      = mem_bus.we;
  assign mem_addr_o    = mem_bus.addr;
  assign mem_wdata_o   = mem_bus.wdata;
  assign mem_bus.rdata = mem_rdata_i;
  assign mem_bus.ack   = mem_ack_i;

  // The sequencer issues one memory word at a time; a single port keeps bus order strict.
  always_comb begin
    nxt_st     = st_ff;
    nxt_ret    = ret_ff;
    nxt_op     = op_ff;
    nxt_ip     = ip_ff;
    nxt_cs     = cs_ff;
    nxt_sp     = sp_ff;
    nxt_new_ip = new_ip_ff;
    nxt_new_cs = new_cs_ff;
    nxt_ptr    = ptr_ff;
    nxt_pop    = pop_ff;
    nxt_pseg   = pseg_ff;
    nxt_done   = 1'b0;
    nxt_flush  = 1'b0;
    go         = 1'b0;
    we         = 1'b0;
    addr       = 20'h00000;
    wdata      = 16'h0000;
    unique case (st_ff)
      S_IDLE: begin
        if (start_i) begin
          nxt_op     = op_i;
          nxt_ip     = next_ip_i;
          nxt_new_cs = cs_ff;
          nxt_ptr    = ind_addr_i;
          nxt_pseg   = data_seg_i;
          nxt_pop    = pop_val_i;
          unique case (op_i)
            ptu_pkg::PTU_OP_CALL_NEAR_DIR: begin
              nxt_new_ip = next_ip_i + disp_i;
              nxt_st     = S_PUSH2;
            end
            ptu_pkg::PTU_OP_CALL_NEAR_IND: begin
              nxt_st = ind_reg_i ? S_PUSH2 : S_RD1;
              nxt_new_ip = target_off_i;
            end
            ptu_pkg::PTU_OP_CALL_FAR_DIR: begin
              nxt_new_ip = target_off_i;
              nxt_new_cs = target_seg_i;
              nxt_st     = S_PUSH1;
            end
            ptu_pkg::PTU_OP_CALL_FAR_IND: nxt_st = S_RD1;
            ptu_pkg::PTU_OP_RET_NEAR,
            ptu_pkg::PTU_OP_RET_FAR: begin
              nxt_ptr  = sp_ff;
              nxt_pseg = stack_seg_i;
              nxt_st   = S_RD1;
            end
            ptu_pkg::PTU_OP_JMP_SHORT: begin
              nxt_new_ip = next_ip_i + {{8{disp_i[7]}}, disp_i[7:0]};
              nxt_st     = S_XFER;
            end
            ptu_pkg::PTU_OP_JMP_NEAR: begin
              nxt_new_ip = next_ip_i + disp_i;
              nxt_st     = S_XFER;
            end
            ptu_pkg::PTU_OP_JMP_NEAR_IND: begin
              nxt_new_ip = target_off_i;
              nxt_st     = ind_reg_i ? S_XFER : S_RD1;
            end
            ptu_pkg::PTU_OP_JMP_FAR_DIR: begin
              nxt_new_ip = target_off_i;
              nxt_new_cs = target_seg_i;
              nxt_st     = S_XFER;
            end
            ptu_pkg::PTU_OP_JMP_FAR_IND: nxt_st = S_RD1;
            ptu_pkg::PTU_OP_JCC: begin
              nxt_new_ip = next_ip_i + {{8{disp_i[7]}}, disp_i[7:0]};
              nxt_st     = cond_taken ? S_XFER : S_IDLE;
              nxt_done   = !cond_taken;
            end
            default: nxt_done = 1'b1;
          endcase
        end
      end
      S_PUSH1: begin
        nxt_sp  = sp_ff - ptu_pkg::STEP_WORD;
        go      = 1'b1;
        we      = 1'b1;
        addr    = phys(stack_seg_i, sp_ff - ptu_pkg::STEP_WORD);
        wdata   = cs_ff;
        nxt_ret = S_PUSH2;
        nxt_st  = S_WAIT;
      end
      S_PUSH2: begin
        nxt_sp  = sp_ff - ptu_pkg::STEP_WORD;
        go      = 1'b1;
        we      = 1'b1;
        addr    = phys(stack_seg_i, sp_ff - ptu_pkg::STEP_WORD);
        wdata   = ip_ff;
        nxt_ret = S_XFER;
        nxt_st  = S_WAIT;
      end
      S_RD1: begin
        go      = 1'b1;
        addr    = phys(pseg_ff, ptr_ff);
        nxt_st  = S_WAIT;
        nxt_ret = S_RD1;
      end
      S_RD2: begin
        go      = 1'b1;
        addr    = phys(pseg_ff, ptr_ff + ptu_pkg::STEP_WORD);
        nxt_st  = S_WAIT;
        nxt_ret = S_RD2;
      end
      S_WAIT: begin
        if (port_done) begin
          nxt_st = ret_ff;
          if (ret_ff == S_RD1) begin
            nxt_new_ip = port_rdata;
            unique case (op_ff)
              ptu_pkg::PTU_OP_RET_NEAR: begin
                nxt_sp = sp_ff + ptu_pkg::STEP_WORD + pop_ff;
                nxt_st = S_XFER;
              end
              ptu_pkg::PTU_OP_RET_FAR: begin
                nxt_sp = sp_ff + ptu_pkg::STEP_WORD;
                nxt_st = S_RD2;
              end
              ptu_pkg::PTU_OP_CALL_NEAR_IND: nxt_st = S_PUSH2;
              ptu_pkg::PTU_OP_CALL_FAR_IND:  nxt_st = S_RD2;
              ptu_pkg::PTU_OP_JMP_FAR_IND:   nxt_st = S_RD2;
              default:                       nxt_st = S_XFER;
            endcase
          end else if (ret_ff == S_RD2) begin
            nxt_new_cs = port_rdata;
            if (op_ff == ptu_pkg::PTU_OP_RET_FAR) begin
              nxt_sp = sp_ff + ptu_pkg::STEP_WORD + pop_ff;
              nxt_st = S_XFER;
            end else if (op_ff == ptu_pkg::PTU_OP_CALL_FAR_IND) begin
              nxt_st = S_PUSH1;
            end else begin
              nxt_st = S_XFER;
            end
          end
        end
      end
      S_XFER: begin
        nxt_ip    = new_ip_ff;
        nxt_cs    = new_cs_ff;
        nxt_flush = 1'b1;
        nxt_st    = S_FLUSH;
      end
      S_FLUSH: begin
        nxt_done = 1'b1;
        nxt_st   = S_IDLE;
      end
      default: nxt_st = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff     <= S_IDLE;
      ret_ff    <= S_IDLE;
      op_ff     <= 4'h0;
      ip_ff     <= ptu_pkg::IP_RESET;
      cs_ff     <= ptu_pkg::CS_RESET;
      sp_ff     <= ptu_pkg::SP_RESET;
      new_ip_ff <= 16'h0000;
      new_cs_ff <= 16'h0000;
      ptr_ff    <= 16'h0000;
      pop_ff    <= 16'h0000;
      pseg_ff   <= 16'h0000;
      done_ff   <= 1'b0;
      flush_ff  <= 1'b0;
    end else begin
      st_ff     <= nxt_st;
      ret_ff    <= nxt_ret;
      op_ff     <= nxt_op;
      ip_ff     <= nxt_ip;
      cs_ff     <= nxt_cs;
      sp_ff     <= nxt_sp;
      new_ip_ff <= nxt_new_ip;
      new_cs_ff <= nxt_new_cs;
      ptr_ff    <= nxt_ptr;
      pop_ff    <= nxt_pop;
      pseg_ff   <= nxt_pseg;
      done_ff   <= nxt_done;
      flush_ff  <= nxt_flush;
    end
  end

  // Flags are inputs only, so no transfer here can alter them.
  assign instr_pointer_o     = ip_ff;
  assign code_segment_base_o = cs_ff;
  assign stack_ptr_o         = sp_ff;
  assign fetch_addr_o        = phys(cs_ff, ip_ff);
  assign queue_flush_o       = flush_ff;
  assign direct_fetch_o      = flush_ff;
  assign busy_o              = (st_ff != S_IDLE);
  assign done_o              = done_ff;
endmodule
